/* File: rtl/aip_conv_if.sv */
// link between parameter logic and the recovery timer
interface aip_conv_if;
  logic       start;
  logic [2:0] recovery_sel;
  logic [2:0] exponent;
  logic       done;
  logic       busy;

  modport ctrl  (output start, output recovery_sel, output exponent,
                 input done, input busy);
  modport timer (input start, input recovery_sel, input exponent,
                 output done, output busy);
endinterface : aip_conv_if

/* File: rtl/aip_offset_adder.sv */
// expands the compressed offset and adds it to each raw difference
module aip_offset_adder (
  // clock and reset
  input  wire logic                               hclk,
  input  wire logic                               hresetn,
  input  wire logic                               ce,
  // raw difference in
  input  wire logic                               in_valid,
  input  wire logic signed [aip_pkg::DIFF_W-1:0]  in_diff,
  input  wire logic                               in_overrange,
  input  wire logic [7:0]                         offset_code,
  // offset result out
  output logic                                    out_valid,
  output logic [aip_pkg::RESULT_W-1:0]            out_result,
  output logic                                    out_overrange
);

  typedef struct packed {
    logic                          valid;
    logic [aip_pkg::RESULT_W-1:0]  result;
    logic                          ovr;
  } aip_adder_s;

  aip_adder_s         state_reg;
  aip_adder_s         state_next;
  logic [19:0]        wide_mant;
  logic [15:0]        offset_val;
  logic signed [18:0] sum;

  // 0x60 -> 64, 0x70 -> 128, 0x80 -> 256: (16+m) << e >> 4
  assign wide_mant  = 20'({aip_pkg::CMP_HIDDEN_ONE[4],
                           offset_code[aip_pkg::CMP_MANT_W-1:0]}) <<
                      offset_code[7:aip_pkg::CMP_EXP_LSB];
  assign offset_val = (offset_code == 8'h00) ? 16'h0000 : wide_mant[19:4];
  assign sum        = 19'(in_diff) + $signed({3'h0, offset_val});

  // saturate instead of wrapping; negative leftovers clamp to zero
  always_comb begin
    state_next       = state_reg;
    state_next.valid = in_valid;
    if (in_valid) begin
      if (in_overrange || sum >= $signed({3'h0, aip_pkg::OVERRANGE_CODE})) begin
        state_next.result = aip_pkg::OVERRANGE_CODE;
        state_next.ovr    = 1'b1;
      end else if (sum < 0) begin
        state_next.result = 16'h0000;
        state_next.ovr    = 1'b0;
      end else begin
        state_next.result = sum[15:0];
        state_next.ovr    = 1'b0;
      end
    end
  end

  // result register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign out_valid     = state_reg.valid;
  assign out_result    = state_reg.result;
  assign out_overrange = state_reg.ovr;

endmodule : aip_offset_adder

/* File: rtl/aip_param_top.sv */
// infrared adc parameter set with ahb-lite register access
module aip_param_top #(
  parameter int              RECOVERY_UNIT_CYCLES = aip_pkg::RECOVERY_UNIT_CYCLES,
  parameter logic [3:0]      SEQ_REVISION         = aip_pkg::MIN_REVISION
) (
  // clock, reset, enable
  input  wire logic                               hclk,
  input  wire logic                               hresetn,
  input  wire logic                               ce,
  // ahb-lite slave
  input  wire logic                               hsel,
  input  wire logic [31:0]                        haddr,
  input  wire logic [1:0]                         htrans,
  input  wire logic                               hwrite,
  input  wire logic [2:0]                         hsize,
  input  wire logic [31:0]                        hwdata,
  input  wire logic                               hready,
  output logic                                    hreadyout,
  output logic                                    hresp,
  output logic [31:0]                             hrdata,
  // sequencer
  input  wire logic                               ir_meas_req,
  output logic                                    ir_busy,
  // adc
  output logic                                    adc_start,
  output logic [7:0]                              adc_clk_div,
  output logic                                    ir_signal_range,
  input  wire logic                               adc_done,
  input  wire logic signed [aip_pkg::DIFF_W-1:0]  adc_diff,
  input  wire logic                               adc_overrange,
  // reported result
  output logic                                    result_valid,
  output logic [aip_pkg::RESULT_W-1:0]            result_data,
  // interrupt
  output logic                                    irq
);

  // every piece of state of this module
  typedef struct packed {
    logic [7:0]                  meas_offset;
    logic [7:0]                  led_rsvd;
    logic [7:0]                  rec_period;
    logic [7:0]                  int_exp;
    logic [7:0]                  range_reg;
    logic [aip_pkg::IRQ_W-1:0]   irq_status;
    logic [aip_pkg::IRQ_W-1:0]   irq_enable;
    logic                        dp_wr;
    logic                        dp_rd;
    logic                        rd_done;
    logic [aip_pkg::IDX_W-1:0]   dp_idx;
    logic [31:0]                 rdata;
    logic [aip_pkg::RESULT_W-1:0] last_result;
    logic                        adc_start;
    logic [7:0]                  adc_div;
    logic                        range_out;
    logic                        res_valid;
    logic [aip_pkg::RESULT_W-1:0] res_data;
  } aip_top_s;

  localparam aip_top_s TOP_RESET = '{
    meas_offset: aip_pkg::MEAS_OFFSET_RESET,
    led_rsvd:    aip_pkg::LED_RSVD_RESET,
    rec_period:  aip_pkg::IR_REC_RESET,
    int_exp:     aip_pkg::IR_EXP_RESET,
    range_reg:   aip_pkg::IR_SIG_RANGE_RESET,
    irq_enable:  aip_pkg::IRQ_ENABLE_RESET,
    adc_div:     8'h01,
    default:     '0
  };

  aip_top_s state_reg;
  aip_top_s state_next;

  // helper wires
  logic                          addr_take;
  logic                          rev_ok;
  logic [2:0]                    eff_rec_sel;
  logic [2:0]                    eff_exp;
  logic [aip_pkg::IRQ_W-1:0]     irq_events;
  logic [31:0]                   read_mux;
  logic                          add_valid;
  logic [aip_pkg::RESULT_W-1:0]  add_result;
  logic                          add_ovr;

  aip_conv_if conv ();

  // address phase is taken only when the bus is ready
  assign addr_take = hsel & hready & htrans[1];

  // older sequencers ignore recovery and exponent settings
  assign rev_ok      = (SEQ_REVISION >= aip_pkg::MIN_REVISION);
  assign eff_rec_sel = rev_ok ?
    state_reg.rec_period[aip_pkg::REC_SEL_LSB +: aip_pkg::REC_SEL_W] : 3'h0;
  assign eff_exp     = rev_ok ?
    state_reg.int_exp[aip_pkg::EXP_LSB +: aip_pkg::EXP_W] : 3'h0;

  // request to the recovery timer; ignored while a recovery runs
  assign conv.start        = ir_meas_req & ~conv.busy;
  assign conv.recovery_sel = eff_rec_sel;
  assign conv.exponent     = eff_exp;

  aip_recovery_timer #(
    .UNIT_CYCLES (RECOVERY_UNIT_CYCLES)
  ) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .conv    (conv)
  );

  aip_offset_adder u_adder (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .ce            (ce),
    .in_valid      (adc_done),
    .in_diff       (adc_diff),
    .in_overrange  (adc_overrange),
    .offset_code   (state_reg.meas_offset),
    .out_valid     (add_valid),
    .out_result    (add_result),
    .out_overrange (add_ovr)
  );

  // hardware events feeding the sticky status
  always_comb begin
    irq_events                         = '0;
    irq_events[aip_pkg::IRQ_RECOVERED] = conv.done;
    irq_events[aip_pkg::IRQ_RESULT]    = add_valid;
    irq_events[aip_pkg::IRQ_OVERRANGE] = add_valid & add_ovr;
  end

  // read data for the index in the data phase; unmapped reads zero
  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (state_reg.dp_idx)
      aip_pkg::IDX_MEAS_OFFSET:   read_mux[7:0] = state_reg.meas_offset;
      aip_pkg::IDX_LED_RSVD:      read_mux[7:0] = state_reg.led_rsvd;
      aip_pkg::IDX_IR_REC_PERIOD: read_mux[7:0] = state_reg.rec_period;
      aip_pkg::IDX_IR_INT_EXP:    read_mux[7:0] = state_reg.int_exp;
      aip_pkg::IDX_IR_SIG_RANGE:  read_mux[7:0] = state_reg.range_reg;
      aip_pkg::IDX_IRQ_STATUS:    read_mux[aip_pkg::IRQ_W-1:0] = state_reg.irq_status;
      aip_pkg::IDX_IRQ_ENABLE:    read_mux[aip_pkg::IRQ_W-1:0] = state_reg.irq_enable;
      aip_pkg::IDX_RESULT: begin
        read_mux[aip_pkg::RESULT_W-1:0]      = state_reg.last_result;
        read_mux[aip_pkg::RESULT_BUSY_BIT]   = conv.busy;
      end
      default:                    read_mux = 32'h0000_0000;
    endcase
  end

  // next state: bus phases, register writes, events, adc outputs
  always_comb begin
    logic [aip_pkg::IRQ_W-1:0] clr_mask;
    clr_mask   = '0;
    state_next = state_reg;

    // bus data phases: writes finish at once, reads take one wait
    if (state_reg.dp_wr) begin
      state_next.dp_wr = 1'b0;
      unique case (state_reg.dp_idx)
        aip_pkg::IDX_MEAS_OFFSET:   state_next.meas_offset = hwdata[7:0];
        aip_pkg::IDX_LED_RSVD:      state_next.led_rsvd    = hwdata[7:0];
        aip_pkg::IDX_IR_REC_PERIOD: state_next.rec_period  = hwdata[7:0];
        aip_pkg::IDX_IR_INT_EXP:    state_next.int_exp     = hwdata[7:0];
        // whole byte stored so reserved bits read back as written
        aip_pkg::IDX_IR_SIG_RANGE:  state_next.range_reg   = hwdata[7:0];
        aip_pkg::IDX_IRQ_CLEAR:     clr_mask = hwdata[aip_pkg::IRQ_W-1:0];
        aip_pkg::IDX_IRQ_ENABLE:
          state_next.irq_enable = hwdata[aip_pkg::IRQ_W-1:0];
        default:                    clr_mask = '0;
      endcase
    end

    if (state_reg.dp_rd && !state_reg.rd_done) begin
      state_next.rdata   = read_mux;
      state_next.rd_done = 1'b1;
    end else if (state_reg.rd_done) begin
      state_next.dp_rd   = 1'b0;
      state_next.rd_done = 1'b0;
    end

    // new address phase; hreadyout low during a read wait blocks it
    if (addr_take) begin
      state_next.dp_wr  = hwrite;
      state_next.dp_rd  = ~hwrite;
      state_next.dp_idx = haddr[aip_pkg::ADDR_IDX_LSB +: aip_pkg::IDX_W];
    end

    // sticky status: a same-cycle event beats its clear
    state_next.irq_status = (state_reg.irq_status & ~clr_mask) | irq_events;

    // hand the recovered request on to the adc
    state_next.adc_start = conv.done;
    state_next.adc_div   = 8'(8'h01 << eff_exp);
    state_next.range_out = state_reg.range_reg[aip_pkg::RANGE_BIT];

    // offset result reported and kept for software
    state_next.res_valid = add_valid;
    if (add_valid) begin
      state_next.res_data    = add_result;
      state_next.last_result = add_result;
    end
  end

  // one register for the whole state, frozen while ce is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= TOP_RESET;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // bus answers: always okay, one wait state on reads only
  assign hreadyout = ~(state_reg.dp_rd & ~state_reg.rd_done);
  assign hresp     = aip_pkg::HRESP_OKAY;
  assign hrdata    = state_reg.rdata;

  // adc and sequencer outputs
  assign adc_start       = state_reg.adc_start;
  assign adc_clk_div     = state_reg.adc_div;
  assign ir_signal_range = state_reg.range_out;
  assign ir_busy         = conv.busy;

  assign result_valid = state_reg.res_valid;
  assign result_data  = state_reg.res_data;

  // level interrupt while any enabled status bit is set
  assign irq = |(state_reg.irq_status & state_reg.irq_enable);

endmodule : aip_param_top

/* File: rtl/aip_pkg.sv */
// constants shared by the infrared adc parameter set and its helpers
package aip_pkg;

  // register indices; byte address is four times the index
  localparam int          IDX_W              = 8;
  localparam int          ADDR_IDX_LSB       = 2;
  localparam logic [7:0]  IDX_MEAS_OFFSET    = 8'h1a;
  localparam logic [7:0]  IDX_LED_RSVD       = 8'h1c;
  localparam logic [7:0]  IDX_IR_REC_PERIOD  = 8'h1d;
  localparam logic [7:0]  IDX_IR_INT_EXP     = 8'h1e;
  localparam logic [7:0]  IDX_IR_SIG_RANGE   = 8'h1f;
  localparam logic [7:0]  IDX_IRQ_STATUS     = 8'h20;
  localparam logic [7:0]  IDX_IRQ_CLEAR      = 8'h21;
  localparam logic [7:0]  IDX_IRQ_ENABLE     = 8'h22;
  localparam logic [7:0]  IDX_RESULT         = 8'h23;

  // reset values
  localparam logic [7:0]  MEAS_OFFSET_RESET  = 8'h80;
  localparam logic [7:0]  LED_RSVD_RESET     = 8'h00;
  localparam logic [7:0]  IR_REC_RESET       = 8'h70;
  localparam logic [7:0]  IR_EXP_RESET       = 8'h00;
  localparam logic [7:0]  IR_SIG_RANGE_RESET = 8'h00;
  localparam logic [2:0]  IRQ_ENABLE_RESET   = 3'h0;

  // field positions
  localparam int          REC_SEL_LSB        = 4;
  localparam int          REC_SEL_W          = 3;
  localparam int          EXP_LSB            = 0;
  localparam int          EXP_W              = 3;
  localparam int          RANGE_BIT          = 5;
  localparam int          RESULT_BUSY_BIT    = 16;

  // compressed offset: upper nibble exponent, lower nibble mantissa
  localparam int          CMP_EXP_LSB        = 4;
  localparam int          CMP_MANT_W         = 4;
  localparam logic [4:0]  CMP_HIDDEN_ONE     = 5'h10;

  // interrupt status layout
  localparam int          IRQ_W              = 3;
  localparam int          IRQ_RECOVERED      = 0;
  localparam int          IRQ_RESULT         = 1;
  localparam int          IRQ_OVERRANGE      = 2;

  // measurement data
  localparam int          RESULT_W           = 16;
  localparam int          DIFF_W             = 17;
  localparam logic [15:0] OVERRANGE_CODE     = 16'hffff;

  // sequencer revisions before this one lack recovery and exponent
  localparam int          REV_W              = 4;
  localparam logic [3:0]  MIN_REVISION       = 4'h3;

  // timing: one recovery adc clock, rounded up to system clocks
  localparam int          CLK_FREQ_MHZ       = 50;
  localparam int          RECOVERY_CLOCK_NS  = 50;
  localparam int          RECOVERY_UNIT_CYCLES =
    (RECOVERY_CLOCK_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int          REC_CNT_W          = 24;

  // recovery length in adc clocks for select codes 0..7
  localparam logic [7:0][8:0] REC_CLOCKS = {9'h1ff, 9'h0ff, 9'h07f, 9'h03f,
                                            9'h01f, 9'h00f, 9'h007, 9'h001};

  // ahb-lite response
  localparam logic        HRESP_OKAY         = 1'b0;

endpackage : aip_pkg

/* File: rtl/aip_recovery_timer.sv */
// recovery wait ahead of an infrared ambient conversion
module aip_recovery_timer #(
  parameter int UNIT_CYCLES = aip_pkg::RECOVERY_UNIT_CYCLES
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  // control side
  aip_conv_if.timer conv
);

  typedef struct packed {
    logic                           busy;
    logic                           done;
    logic [aip_pkg::REC_CNT_W-1:0]  count;
  } aip_timer_s;

  aip_timer_s state_reg;
  aip_timer_s state_next;
  logic [aip_pkg::REC_CNT_W-1:0] base_len;

  // adc clocks times system clocks per adc clock
  assign base_len = aip_pkg::REC_CNT_W'(conv.recovery_sel == 3'h0 ? 9'h001 :
                      aip_pkg::REC_CLOCKS[conv.recovery_sel]) *
                    aip_pkg::REC_CNT_W'(UNIT_CYCLES);

  // load on start, count down, pulse done in the cycle busy falls after the last count
  always_comb begin
    state_next      = state_reg;
    state_next.done = 1'b0;
    if (!state_reg.busy) begin
      if (conv.start) begin
        state_next.busy  = 1'b1;
        state_next.count = base_len << conv.exponent;
      end
    end else if (state_reg.count <= aip_pkg::REC_CNT_W'(1)) begin
      state_next.busy = 1'b0;
      state_next.done = 1'b1;
    end else begin
      state_next.count = state_reg.count - aip_pkg::REC_CNT_W'(1);
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign conv.busy = state_reg.busy;
  assign conv.done = state_reg.done;

endmodule : aip_recovery_timer

/* File: verif/aip_param_checker.sv */
// port assertions for the infrared adc parameter set
module aip_param_checker #(
  parameter logic [3:0] SEQ_REVISION = aip_pkg::MIN_REVISION
) (
  // clock, reset, enable
  input wire logic                      hclk,
  input wire logic                      hresetn,
  input wire logic                      ce,
  // register bus
  input wire logic                      hsel,
  input wire logic [1:0]                htrans,
  input wire logic                      hwrite,
  input wire logic                      hready,
  input wire logic                      hreadyout,
  input wire logic                      hresp,
  // measurement path
  input wire logic                      ir_meas_req,
  input wire logic                      ir_busy,
  input wire logic                      adc_start,
  input wire logic [7:0]                adc_clk_div,
  input wire logic                      adc_done,
  input wire logic                      adc_overrange,
  input wire logic                      result_valid,
  input wire logic [aip_pkg::RESULT_W-1:0] result_data
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // bus answers: okay always, reads wait exactly one cycle, writes none
  a_bus_okay: assert property (hresp == aip_pkg::HRESP_OKAY)
    else $error("bus response not okay");
  a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite && ce
    |=> !hreadyout ##1 hreadyout) else $error("read wait is not one cycle");
  a_write_nowait: assert property (hsel && hready && htrans[1] && hwrite && ce
    |=> hreadyout) else $error("write inserted a wait");
  // recovery starts on an idle request and hands over to the adc
  a_busy_on_req: assert property (ir_meas_req && !ir_busy && ce |=> ir_busy)
    else $error("request did not start recovery");
  // done is registered first, so the start pulse comes one cycle after busy falls
  a_start_after: assert property ($fell(ir_busy) |->
    !adc_start ##1 adc_start ##1 !adc_start)
    else $error("conversion start not a pulse after recovery");
  // each result follows its sample by two cycles (adder, then output stage)
  a_result_next: assert property (adc_done && ce |=> ##1 result_valid)
    else $error("result did not follow sample");
  a_result_held: assert property ($changed(result_data) |-> result_valid)
    else $error("result changed without valid");
  a_ovr_code: assert property (adc_done && adc_overrange && ce
    |=> ##1 result_data == aip_pkg::OVERRANGE_CODE) else $error("overrange not reported");
  // divider is a power of two, and one for old revisions
  a_div_pow: assert property ($onehot(adc_clk_div) &&
    (SEQ_REVISION >= aip_pkg::MIN_REVISION || adc_clk_div == 8'h01))
    else $error("adc clock divider illegal");
endmodule : aip_param_checker

bind aip_param_top aip_param_checker #(.SEQ_REVISION(SEQ_REVISION)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .ir_meas_req(ir_meas_req), .ir_busy(ir_busy), .adc_start(adc_start),
  .adc_clk_div(adc_clk_div), .adc_done(adc_done), .adc_overrange(adc_overrange),
  .result_valid(result_valid), .result_data(result_data));

/* File: verif/aip_param_top_tb.sv */
// self-checking bench for the infrared adc parameter set
module aip_param_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic               hclk, hresetn, ce, hsel, hwrite, ir_meas_req, adc_done, adc_overrange;
  logic [31:0]        haddr, hwdata, hrdata;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic signed [16:0] adc_diff;
  logic               hreadyout, hresp, ir_busy, adc_start, ir_signal_range;
  logic               result_valid, irq;
  logic [7:0]         adc_clk_div;
  logic [15:0]        result_data;
  int                 miscompares = 0;
  int                 compares = 0;
  logic [31:0]        v;

  // unit of one cycle keeps the longest recovery short
  aip_param_top #(.RECOVERY_UNIT_CYCLES(1)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ir_meas_req(ir_meas_req), .ir_busy(ir_busy), .adc_start(adc_start),
    .adc_clk_div(adc_clk_div), .ir_signal_range(ir_signal_range),
    .adc_done(adc_done), .adc_diff(adc_diff), .adc_overrange(adc_overrange),
    .result_valid(result_valid), .result_data(result_data), .irq(irq));

  // 50 mhz clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic final_report;
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one single ahb transfer; starts right after an edge, ends on the edge it completes
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    htrans <= 2'b10;
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, idx, d, x);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    xfer(1'b0, idx, 32'h0, d);
    chk(what, exp, d);
  endtask : rd_chk

  // one adc sample; result stands in the second cycle after it is taken
  task automatic meas(input logic [16:0] diff, input logic ovr, input logic [15:0] exp);
    adc_done      <= 1'b1;
    adc_diff      <= diff;
    adc_overrange <= ovr;
    @(posedge hclk);
    adc_done <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("result_valid", 32'h1, {31'h0, result_valid});
    chk("result_data", {16'h0, exp}, {16'h0, result_data});
  endtask : meas

  // recovery length: adc clocks of the select code scaled by two to the exponent
  task automatic rec(input int sel, input int ex);
    int n;
    int exp_n;
    wr(aip_pkg::IDX_IR_REC_PERIOD, 32'(sel << 4));
    wr(aip_pkg::IDX_IR_INT_EXP, 32'(ex));
    ir_meas_req <= 1'b1;
    @(posedge hclk);
    ir_meas_req <= 1'b0;
    n = 0;
    @(posedge hclk);
    while (ir_busy === 1'b1 && n < 5000) begin
      n++;
      @(posedge hclk);
    end
    exp_n = (sel == 0 ? 1 : (1 << (sel + 2)) - 1) << ex;
    chk("busy_cycles", 32'(exp_n), 32'(n));
    // start pulse is launched one edge after busy is seen low
    @(posedge hclk);
    chk("adc_start", 32'h1, {31'h0, adc_start});
    chk("adc_clk_div", 32'(1 << ex), {24'h0, adc_clk_div});
  endtask : rec

  // watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    final_report();
  end

  initial begin
    static logic [7:0]  idx_t [9] = '{8'h1a, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h22, 8'h23,
                                      8'h30};
    static logic [31:0] rst_t [9] = '{32'h80, 32'h0, 32'h70, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
                                      32'h0};
    static logic [7:0]  code_t [3] = '{8'h60, 8'h70, 8'h80};
    static logic [15:0] offs_t [3] = '{16'h0040, 16'h0080, 16'h0100};
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ir_meas_req = 1'b0;
    adc_done = 1'b0;
    adc_diff = 17'h0;
    adc_overrange = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 9; i++) rd_chk("reset_value", idx_t[i], rst_t[i]);
    wr(8'h1b, 32'h5a);
    rd_chk("unmapped", 8'h1b, 32'h0);
    // offset codes expand and add to a zero difference
    for (int i = 0; i < 3; i++) begin
      wr(aip_pkg::IDX_MEAS_OFFSET, {24'h0, code_t[i]});
      meas(17'h0, 1'b0, offs_t[i]);
    end
    meas(17'h1ff9c, 1'b0, 16'h009c);
    meas(17'h0fefe, 1'b0, 16'hfffe);
    meas(17'h0feff, 1'b0, 16'hffff);
    meas(17'h00010, 1'b1, 16'hffff);
    rd_chk("result_reg", aip_pkg::IDX_RESULT, 32'h0000ffff);
    // masked status, then enabled, then cleared
    rd_chk("status", aip_pkg::IDX_IRQ_STATUS, 32'h6);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(aip_pkg::IDX_IRQ_ENABLE, 32'h4);
    @(posedge hclk);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(aip_pkg::IDX_IRQ_CLEAR, 32'h4);
    @(posedge hclk);
    chk("irq_off", 32'h0, {31'h0, irq});
    rd_chk("status_left", aip_pkg::IDX_IRQ_STATUS, 32'h2);
    // range bit via read-modify-write keeps the reserved bits
    wr(aip_pkg::IDX_IR_SIG_RANGE, 32'h15);
    xfer(1'b0, aip_pkg::IDX_IR_SIG_RANGE, 32'h0, v);
    wr(aip_pkg::IDX_IR_SIG_RANGE, v | 32'h20);
    repeat (2) @(posedge hclk);
    chk("ir_signal_range", 32'h1, {31'h0, ir_signal_range});
    rd_chk("range_reg", aip_pkg::IDX_IR_SIG_RANGE, 32'h35);
    // every select code, every exponent, short total
    for (int k = 0; k < 8; k++) rec(k, 7 - k);
    rec(2, 3);
    rd_chk("recovered", aip_pkg::IDX_IRQ_STATUS, 32'h3);
    final_report();
  end
endmodule : aip_param_top_tb
